//--- hdl/tsx_step_exec.sv
// step executor of the trigger sequencer with its apb register file
// Functional notes
// - control 0010 disables the step delay
// - control 0110 enables the step delay
// - control 1000 runs timer 0 until limit
// - control 1001 runs timer 1 until limit
// - control 1011 waits for software trigger rise
// - control 1100/1101 load channel select from counter
// - control 1110 loads channel select from literal
// - control 1111 pulses enabled broadcast triggers
// - add 0000/0001 adjusts counter limits
// - add 0010/0011 adjusts timer limits
// - add 0100/0101 adjusts delay limit, literal
// - copy 1000/1001 loads counter limits from hold
// - copy 1010/1011 loads timer limits from hold
// - copy 1100/1101 loads delay limit, literal
// - reserved codes consume step, change nothing
`timescale 1ns/1ps
module tsx_step_exec
  import tsx_pkg::*;
#(
  parameter int DW = 16,
  parameter int NTRIG = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // apb register bus
  input tsx_pkg::tsx_apb_req_t APB_REQ,
  output tsx_pkg::tsx_apb_rsp_t APB_RSP,
  // adc and trigger consumers
  output logic [DW-1:0] ADC_CHSEL,
  output logic ADC_CHSEL_LOAD,
  output logic [NTRIG-1:0] TRIG_OUT
);

  localparam int QAW = $clog2(DEPTH);

  // ************************************************************
  // state
  // ************************************************************
  tsx_state_t state, next_state;
  logic [QAW-1:0] idx, next_idx;
  logic run, next_run;
  logic swt, next_swt;
  logic swt_prev;
  logic sd_en, next_sd_en;
  logic [DW-1:0] adj, next_adj;
  logic [DW-1:0] hold, next_hold;
  logic [DW-1:0] c0lim, next_c0lim;
  logic [DW-1:0] c1lim, next_c1lim;
  logic [DW-1:0] t0lim, next_t0lim;
  logic [DW-1:0] t1lim, next_t1lim;
  logic [DW-1:0] sdlim, next_sdlim;
  logic [DW-1:0] lit0, next_lit0;
  logic [DW-1:0] cnt0, next_cnt0;
  logic [DW-1:0] cnt1, next_cnt1;
  logic [NTRIG-1:0] bte, next_bte;
  logic [DW-1:0] next_chsel;
  logic next_chsel_load;
  logic [NTRIG-1:0] next_trig;
  logic [7:0] queue [DEPTH];
  logic [7:0] next_queue [DEPTH];
  tsx_apb_rsp_t next_rsp;

  logic t0_start, t1_start, sd_start;
  logic t0_hit, t1_hit, sd_hit;
  logic [7:0] step;
  logic [3:0] cmd, opt;
  logic apb_wr, apb_rd, q_hit, advance;
  logic [QAW-1:0] q_addr;

  // ************************************************************
  // timers
  // ************************************************************
  tsx_step_timer #(.DW(DW)) u_timer0 (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .start(t0_start),
    .limit(t0lim),
    .hit(t0_hit)
  );

  tsx_step_timer #(.DW(DW)) u_timer1 (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .start(t1_start),
    .limit(t1lim),
    .hit(t1_hit)
  );

  tsx_step_timer #(.DW(DW)) u_delay (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .start(sd_start),
    .limit(sdlim),
    .hit(sd_hit)
  );

  // ************************************************************
  // apb decode
  // ************************************************************
  // one wait state so read data and pready come straight from flops
  assign apb_wr = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite & APB_RSP.pready;
  assign apb_rd = APB_REQ.psel & APB_REQ.penable & ~APB_RSP.pready;
  assign q_hit = (APB_REQ.paddr[1:0] == 2'h0) && (APB_REQ.paddr >= OFS_QUEUE) &&
                 (int'(APB_REQ.paddr) < int'(OFS_QUEUE) + 4 * DEPTH);
  assign q_addr = APB_REQ.paddr[QAW+1:2];

  always_comb begin
    next_rsp = APB_RSP;
    next_rsp.pready = apb_rd;
    if (apb_rd) begin
      next_rsp.pslverr = 1'b0;
      next_rsp.prdata = RST_VALUE;
      unique case (APB_REQ.paddr)
        OFS_CTRL: begin
          next_rsp.prdata[CTRL_RUN_BIT] = run;
          next_rsp.prdata[CTRL_SWT_BIT] = swt;
        end
        OFS_STATUS: begin
          next_rsp.prdata[STAT_BUSY_BIT] = (state != ST_IDLE);
          next_rsp.prdata[STAT_WAIT_BIT] = (state == ST_WAIT_T0) ||
            (state == ST_WAIT_T1) || (state == ST_WAIT_SWT);
          next_rsp.prdata[STAT_SDEN_BIT] = sd_en;
          next_rsp.prdata[STAT_IDX_LSB +: QAW] = idx;
        end
        OFS_ADJUST: next_rsp.prdata[DW-1:0] = adj;
        OFS_HOLD: next_rsp.prdata[DW-1:0] = hold;
        OFS_C0LIM: next_rsp.prdata[DW-1:0] = c0lim;
        OFS_C1LIM: next_rsp.prdata[DW-1:0] = c1lim;
        OFS_T0LIM: next_rsp.prdata[DW-1:0] = t0lim;
        OFS_T1LIM: next_rsp.prdata[DW-1:0] = t1lim;
        OFS_SDLIM: next_rsp.prdata[DW-1:0] = sdlim;
        OFS_LIT0: next_rsp.prdata[DW-1:0] = lit0;
        OFS_BTE: next_rsp.prdata[NTRIG-1:0] = bte;
        OFS_CNT0: next_rsp.prdata[DW-1:0] = cnt0;
        OFS_CNT1: next_rsp.prdata[DW-1:0] = cnt1;
        OFS_CHSEL: next_rsp.prdata[DW-1:0] = ADC_CHSEL;
        default: begin
          if (q_hit) begin
            next_rsp.prdata[7:0] = queue[q_addr];
          end else begin
            next_rsp.pslverr = 1'b1;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // register file and step engine
  // ************************************************************
  assign step = queue[idx];
  assign cmd = step[STEP_CMD_LSB +: 4];
  assign opt = step[3:0];

  always_comb begin
    next_state = state;
    next_idx = idx;
    next_run = run;
    next_swt = swt;
    next_sd_en = sd_en;
    next_adj = adj;
    next_hold = hold;
    next_c0lim = c0lim;
    next_c1lim = c1lim;
    next_t0lim = t0lim;
    next_t1lim = t1lim;
    next_sdlim = sdlim;
    next_lit0 = lit0;
    next_cnt0 = cnt0;
    next_cnt1 = cnt1;
    next_bte = bte;
    next_chsel = ADC_CHSEL;
    next_chsel_load = 1'b0;
    next_trig = '0;
    next_queue = queue;
    t0_start = 1'b0;
    t1_start = 1'b0;
    sd_start = 1'b0;
    advance = 1'b0;

    // software writes first, so a step landing in the same cycle wins
    if (apb_wr) begin
      unique case (APB_REQ.paddr)
        OFS_CTRL: begin
          next_run = APB_REQ.pwdata[CTRL_RUN_BIT];
          next_swt = APB_REQ.pwdata[CTRL_SWT_BIT];
        end
        OFS_ADJUST: next_adj = APB_REQ.pwdata[DW-1:0];
        OFS_HOLD: next_hold = APB_REQ.pwdata[DW-1:0];
        OFS_C0LIM: next_c0lim = APB_REQ.pwdata[DW-1:0];
        OFS_C1LIM: next_c1lim = APB_REQ.pwdata[DW-1:0];
        OFS_T0LIM: next_t0lim = APB_REQ.pwdata[DW-1:0];
        OFS_T1LIM: next_t1lim = APB_REQ.pwdata[DW-1:0];
        OFS_SDLIM: next_sdlim = APB_REQ.pwdata[DW-1:0];
        OFS_LIT0: next_lit0 = APB_REQ.pwdata[DW-1:0];
        OFS_BTE: next_bte = APB_REQ.pwdata[NTRIG-1:0];
        OFS_CNT0: next_cnt0 = APB_REQ.pwdata[DW-1:0];
        OFS_CNT1: next_cnt1 = APB_REQ.pwdata[DW-1:0];
        default: begin
          if (q_hit) begin
            next_queue[q_addr] = APB_REQ.pwdata[7:0];
          end
        end
      endcase
    end

    unique case (state)
      ST_IDLE: begin
        if (run) begin
          next_idx = '0;
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        advance = 1'b1;
        if (cmd == CMD_CONTROL) begin
          case (opt)
            OPT_SD_OFF: next_sd_en = 1'b0;
            OPT_SD_ON: next_sd_en = 1'b1;
            OPT_WAIT_T0: begin
              t0_start = 1'b1;
              advance = 1'b0;
              next_state = ST_WAIT_T0;
            end
            OPT_WAIT_T1: begin
              t1_start = 1'b1;
              advance = 1'b0;
              next_state = ST_WAIT_T1;
            end
            OPT_WAIT_SWT: begin
              advance = 1'b0;
              next_state = ST_WAIT_SWT;
            end
            OPT_CHSEL_C0: begin
              next_chsel = cnt0;
              next_chsel_load = 1'b1;
            end
            OPT_CHSEL_C1: begin
              next_chsel = cnt1;
              next_chsel_load = 1'b1;
            end
            OPT_CHSEL_L0: begin
              next_chsel = lit0;
              next_chsel_load = 1'b1;
            end
            OPT_BCAST: next_trig = bte;
            default: ;
          endcase
        end else if (cmd == CMD_ADDCOPY && !opt[3]) begin
          case (opt[2:0])
            TGT_C0LIM: next_c0lim = c0lim + adj;
            TGT_C1LIM: next_c1lim = c1lim + adj;
            TGT_T0LIM: next_t0lim = t0lim + adj;
            TGT_T1LIM: next_t1lim = t1lim + adj;
            TGT_SDLIM: next_sdlim = sdlim + adj;
            TGT_LIT0: next_lit0 = lit0 + adj;
            default: ;
          endcase
        end else if (cmd == CMD_ADDCOPY) begin
          case (opt[2:0])
            TGT_C0LIM: next_c0lim = hold;
            TGT_C1LIM: next_c1lim = hold;
            TGT_T0LIM: next_t0lim = hold;
            TGT_T1LIM: next_t1lim = hold;
            TGT_SDLIM: next_sdlim = hold;
            TGT_LIT0: next_lit0 = hold;
            default: ;
          endcase
        end
        // any other command is consumed as an empty step
      end
      ST_WAIT_T0: advance = t0_hit;
      ST_WAIT_T1: advance = t1_hit;
      // edge must occur while waiting; an earlier rise is not remembered
      ST_WAIT_SWT: advance = swt & ~swt_prev;
      ST_DELAY: begin
        if (sd_hit) begin
          next_state = ST_EXEC;
        end
      end
    endcase

    if (advance) begin
      next_idx = idx + 1'b1;
      if (next_sd_en) begin
        sd_start = 1'b1;
        next_state = ST_DELAY;
      end else begin
        next_state = ST_EXEC;
      end
    end

    // clearing run aborts any wait or delay in progress; a step already in ST_EXEC still takes effect
    if (!run && state != ST_IDLE) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_IDLE;
      idx <= '0;
      run <= 1'b0;
      swt <= 1'b0;
      swt_prev <= 1'b0;
      sd_en <= 1'b0;
      adj <= '0;
      hold <= '0;
      c0lim <= '0;
      c1lim <= '0;
      t0lim <= '0;
      t1lim <= '0;
      sdlim <= '0;
      lit0 <= '0;
      cnt0 <= '0;
      cnt1 <= '0;
      bte <= '0;
      ADC_CHSEL <= '0;
      ADC_CHSEL_LOAD <= 1'b0;
      TRIG_OUT <= '0;
      APB_RSP <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        queue[i] <= RST_STEP;
      end
    end else begin
      state <= next_state;
      idx <= next_idx;
      run <= next_run;
      swt <= next_swt;
      swt_prev <= swt;
      sd_en <= next_sd_en;
      adj <= next_adj;
      hold <= next_hold;
      c0lim <= next_c0lim;
      c1lim <= next_c1lim;
      t0lim <= next_t0lim;
      t1lim <= next_t1lim;
      sdlim <= next_sdlim;
      lit0 <= next_lit0;
      cnt0 <= next_cnt0;
      cnt1 <= next_cnt1;
      bte <= next_bte;
      ADC_CHSEL <= next_chsel;
      ADC_CHSEL_LOAD <= next_chsel_load;
      TRIG_OUT <= next_trig;
      APB_RSP <= next_rsp;
      queue <= next_queue;
    end
  end

endmodule // tsx_step_exec

//--- hdl/tsx_step_timer.sv
// one-shot up-counter that flags a match against a live limit
`timescale 1ns/1ps
module tsx_step_timer #(
  parameter int DW = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic start,
  input wire logic [DW-1:0] limit,
  // status
  output logic hit
);

  logic [DW-1:0] cnt;
  logic running;
  logic [DW-1:0] next_cnt;
  logic next_running;
  logic next_hit;

  // limit is compared live, so an apb write may retune a running timer
  always_comb begin
    next_cnt = cnt;
    next_running = running;
    next_hit = hit;
    if (start) begin
      next_cnt = '0;
      next_running = 1'b1;
      next_hit = 1'b0;
    end else if (running) begin
      if (cnt == limit) begin
        next_running = 1'b0;
        next_hit = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
      running <= 1'b0;
      hit <= 1'b0;
    end else begin
      cnt <= next_cnt;
      running <= next_running;
      hit <= next_hit;
    end
  end

endmodule // tsx_step_timer

//--- shared/tsx_pkg.sv
// shared constants, codes and carriers of the trigger sequencer step executor
package tsx_pkg;

  // ************************************************************
  // register offsets (byte addresses on the apb bus)
  // ************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ADJUST = 8'h08;
  localparam logic [7:0] OFS_HOLD = 8'h0c;
  localparam logic [7:0] OFS_C0LIM = 8'h10;
  localparam logic [7:0] OFS_C1LIM = 8'h14;
  localparam logic [7:0] OFS_T0LIM = 8'h18;
  localparam logic [7:0] OFS_T1LIM = 8'h1c;
  localparam logic [7:0] OFS_SDLIM = 8'h20;
  localparam logic [7:0] OFS_LIT0 = 8'h24;
  localparam logic [7:0] OFS_BTE = 8'h28;
  localparam logic [7:0] OFS_CNT0 = 8'h2c;
  localparam logic [7:0] OFS_CNT1 = 8'h30;
  localparam logic [7:0] OFS_CHSEL = 8'h34;
  localparam logic [7:0] OFS_QUEUE = 8'h40;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SWT_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WAIT_BIT = 1;
  localparam int STAT_SDEN_BIT = 2;
  localparam int STAT_IDX_LSB = 8;
  localparam logic [31:0] RST_VALUE = 32'h0000_0000;
  localparam logic [7:0] RST_STEP = 8'h00;

  // ************************************************************
  // step layout: command in [7:4], option in [3:0]
  // ************************************************************
  localparam int STEP_CMD_LSB = 4;
  localparam logic [3:0] CMD_CONTROL = 4'h0;
  localparam logic [3:0] CMD_ADDCOPY = 4'h1;

  localparam logic [3:0] OPT_SD_OFF = 4'h2;
  localparam logic [3:0] OPT_SD_ON = 4'h6;
  localparam logic [3:0] OPT_WAIT_T0 = 4'h8;
  localparam logic [3:0] OPT_WAIT_T1 = 4'h9;
  localparam logic [3:0] OPT_WAIT_SWT = 4'hb;
  localparam logic [3:0] OPT_CHSEL_C0 = 4'hc;
  localparam logic [3:0] OPT_CHSEL_C1 = 4'hd;
  localparam logic [3:0] OPT_CHSEL_L0 = 4'he;
  localparam logic [3:0] OPT_BCAST = 4'hf;

  // low three option bits select the target of add and copy steps
  localparam logic [2:0] TGT_C0LIM = 3'h0;
  localparam logic [2:0] TGT_C1LIM = 3'h1;
  localparam logic [2:0] TGT_T0LIM = 3'h2;
  localparam logic [2:0] TGT_T1LIM = 3'h3;
  localparam logic [2:0] TGT_SDLIM = 3'h4;
  localparam logic [2:0] TGT_LIT0 = 3'h5;

  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_EXEC = 6'b000010,
    ST_WAIT_T0 = 6'b000100,
    ST_WAIT_T1 = 6'b001000,
    ST_WAIT_SWT = 6'b010000,
    ST_DELAY = 6'b100000
  } tsx_state_t;

  // ************************************************************
  // apb carriers
  // ************************************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tsx_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tsx_apb_rsp_t;

endpackage

//--- sim/test_trigger_sequencer_step_exec.sv
// self-checking bench of the step executor
`timescale 1ns/1ps
module test_trigger_sequencer_step_exec;
  import tsx_pkg::*;
  localparam logic [7:0] RSV [8] = '{8'h16, 8'h17, 8'h1e, 8'h1f, 8'h00, 8'h07, 8'h0a, 8'h2c};
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  tsx_apb_req_t apb_req = '0;
  tsx_apb_rsp_t apb_rsp;
  logic [15:0] adc_chsel;
  logic adc_chsel_load;
  logic [15:0] trig_out;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  int g0;
  int g1;
  int n0;
  always #10 clk_sys = ~clk_sys;
  tsx_step_exec dut_u (
    .CLK_SYS(clk_sys),
    .ARST_N(arst_n),
    .APB_REQ(apb_req),
    .APB_RSP(apb_rsp),
    .ADC_CHSEL(adc_chsel),
    .ADC_CHSEL_LOAD(adc_chsel_load),
    .TRIG_OUT(trig_out)
  );
  tsx_adc_model adc_u (
    .clk(clk_sys),
    .chsel(adc_chsel),
    .chsel_load(adc_chsel_load),
    .trig(trig_out)
  );
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // extra edge at the end keeps two requests from sharing a time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge clk_sys);
  endtask
  // waiting also covers timer waits, so the index pins the parking step
  task automatic wait_hold(input int at);
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
    end while (rd[STAT_WAIT_BIT] !== 1'b1 || rd[STAT_IDX_LSB +: 4] !== 4'(at));
  endtask
  // four steps then a software trigger wait, which parks the sequencer
  task automatic run4(input logic [7:0] a, b, c, d, output int gap);
    logic [7:0] s [5];
    s = '{a, b, c, d, 8'h0b};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, OFS_QUEUE + 8'(4 * i), {24'h0, s[i]});
    end
    apb(1'b1, OFS_CTRL, 32'h1);
    wait_hold(4);
    apb(1'b1, OFS_CTRL, 32'h0);
    gap = adc_u.t_last - adc_u.t_prev;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_regs();
    apb(1'b0, OFS_C0LIM, 32'h0);
    check("c0lim reset", rd, RST_VALUE);
    apb(1'b1, OFS_HOLD, 32'h1234);
    apb(1'b0, OFS_HOLD, 32'h0);
    check("hold readback", rd, 32'h1234);
    apb(1'b0, 8'h38, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    $display("test regs done");
  endtask
  task automatic test_timers();
    // broadcast steps mark the gaps, so at least one enable must be set
    apb(1'b1, OFS_BTE, 32'h1);
    for (int t = 0; t < 2; t++) begin
      apb(1'b1, OFS_T0LIM + 8'(4 * t), 32'h4);
      run4(8'h0f, 8'h08 + 8'(t), 8'h0f, 8'h03, g0);
      apb(1'b1, OFS_T0LIM + 8'(4 * t), 32'h9);
      run4(8'h0f, 8'h08 + 8'(t), 8'h0f, 8'h03, g1);
      check("timer wait growth", g1 - g0, 32'd5);
    end
    $display("test timers done");
  endtask
  task automatic test_delay();
    run4(8'h0f, 8'h03, 8'h0f, 8'h03, g0);
    check("gap without delay", g0, 32'd2);
    apb(1'b1, OFS_SDLIM, 32'h6);
    run4(8'h06, 8'h0f, 8'h0f, 8'h03, g0);
    check("gap with delay", g0, 32'd9);
    run4(8'h06, 8'h02, 8'h0f, 8'h0f, g0);
    check("gap after disable", g0, 32'd1);
    $display("test delay done");
  endtask
  task automatic test_addcopy();
    apb(1'b1, OFS_ADJUST, 32'h3);
    apb(1'b1, OFS_HOLD, 32'h77);
    n0 = adc_u.n_load + adc_u.n_trig;
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, OFS_C0LIM + 8'(4 * k), 32'(16 * k + 1));
      apb(1'b1, OFS_QUEUE + 8'(4 * k), 32'h10 + 32'(k));
    end
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, OFS_QUEUE + 8'(24 + 4 * k), {24'h0, RSV[k]});
    end
    apb(1'b1, OFS_QUEUE + 8'h38, 32'h0b);
    apb(1'b1, OFS_CTRL, 32'h1);
    wait_hold(14);
    apb(1'b1, OFS_CTRL, 32'h0);
    check("reserved outputs", adc_u.n_load + adc_u.n_trig, n0);
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, OFS_C0LIM + 8'(4 * k), 32'h0);
      check("add target", rd, 32'(16 * k + 4));
    end
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, OFS_QUEUE + 8'(4 * k), 32'h18 + 32'(k));
    end
    apb(1'b1, OFS_QUEUE + 8'h18, 32'h0b);
    apb(1'b1, OFS_CTRL, 32'h1);
    wait_hold(6);
    apb(1'b1, OFS_CTRL, 32'h0);
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, OFS_C0LIM + 8'(4 * k), 32'h0);
      check("copy target", rd, 32'h77);
    end
    $display("test addcopy done");
  endtask
  task automatic test_chsel();
    apb(1'b1, OFS_CNT0, 32'h7);
    apb(1'b1, OFS_CNT1, 32'h9);
    apb(1'b1, OFS_LIT0, 32'h21);
    n0 = adc_u.n_load;
    run4(8'h0c, 8'h0d, 8'h0e, 8'h03, g0);
    check("load count", adc_u.n_load - n0, 32'd3);
    check("from counter0", {16'h0, adc_u.chan[2]}, 32'h7);
    check("from counter1", {16'h0, adc_u.chan[1]}, 32'h9);
    check("from literal", {16'h0, adc_u.chan[0]}, 32'h21);
    apb(1'b0, OFS_CHSEL, 32'h0);
    check("chsel register", rd, 32'h21);
    $display("test chsel done");
  endtask
  task automatic test_swt();
    apb(1'b1, OFS_BTE, 32'ha5);
    apb(1'b1, OFS_QUEUE, 32'h0b);
    apb(1'b1, OFS_QUEUE + 8'h4, 32'h0f);
    apb(1'b1, OFS_QUEUE + 8'h8, 32'h0b);
    n0 = adc_u.n_trig;
    apb(1'b1, OFS_CTRL, 32'h1);
    wait_hold(0);
    check("held before rise", adc_u.n_trig - n0, 32'd0);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h3);
    repeat (4) @(posedge clk_sys);
    wait_hold(2);
    apb(1'b1, OFS_CTRL, 32'h0);
    check("one broadcast", adc_u.n_trig - n0, 32'd1);
    check("broadcast set", {16'h0, adc_u.trig_seen}, 32'ha5);
    $display("test swt done");
  endtask
  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    test_regs();
    test_timers();
    test_delay();
    test_addcopy();
    test_chsel();
    test_swt();
    tally_and_finish();
  end
endmodule // test_trigger_sequencer_step_exec

//--- sim/tsx_adc_model.sv
// behavioural adc and trigger consumer on the far side
`timescale 1ns/1ps
module tsx_adc_model #(
  parameter int DW = 16,
  parameter int NTRIG = 16
) (
  // clock
  input wire logic clk,
  // adc and trigger inputs
  input wire logic [DW-1:0] chsel,
  input wire logic chsel_load,
  input wire logic [NTRIG-1:0] trig
);
  int cyc = 0;
  int n_load = 0;
  int n_trig = 0;
  int t_prev = 0;
  int t_last = 0;
  logic [DW-1:0] chan [3];
  logic [NTRIG-1:0] trig_seen = '0;
  // newest load in chan[0]; pulse times give step spacing
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (chsel_load) begin
      chan[0] <= chsel;
      chan[1] <= chan[0];
      chan[2] <= chan[1];
      n_load <= n_load + 1;
    end
    if (|trig) begin
      trig_seen <= trig;
      n_trig <= n_trig + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
  end
endmodule // tsx_adc_model

//--- sim/tsx_step_exec_assertions.sv
// port checker of the step executor, bound into the design
`timescale 1ns/1ps
module tsx_step_exec_assertions
  import tsx_pkg::*;
#(
  parameter int DW = 16,
  parameter int NTRIG = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // apb register bus
  input tsx_pkg::tsx_apb_req_t APB_REQ,
  input tsx_pkg::tsx_apb_rsp_t APB_RSP,
  // adc and trigger consumers
  input wire logic [DW-1:0] ADC_CHSEL,
  input wire logic ADC_CHSEL_LOAD,
  input wire logic [NTRIG-1:0] TRIG_OUT
);
  logic [NTRIG-1:0] bte;
  logic [NTRIG-1:0] next_bte;
  logic acc;
  logic mapped;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  assign acc = APB_REQ.psel && APB_REQ.penable;
  assign mapped = APB_REQ.paddr[1:0] == 2'h0 && (APB_REQ.paddr <= OFS_CHSEL ||
    (APB_REQ.paddr >= OFS_QUEUE && APB_REQ.paddr < OFS_QUEUE + 8'(4 * DEPTH)));
  // shadow of the trigger enables, so pulses can be judged
  always_comb begin
    next_bte = bte;
    if (acc && APB_RSP.pready && APB_REQ.pwrite && APB_REQ.paddr == OFS_BTE) begin
      next_bte = APB_REQ.pwdata[NTRIG-1:0];
    end
  end
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      bte <= '0;
    end else begin
      bte <= next_bte;
    end
  end
  // ************************************************************
  // assertions
  // ************************************************************
  rdy_wait_a: assert property (acc && !APB_RSP.pready |=> APB_RSP.pready)
    else $error("pready missing after access cycle");
  rdy_pulse_a: assert property (APB_RSP.pready |=> !APB_RSP.pready)
    else $error("pready held beyond one cycle");
  rdy_cause_a: assert property (APB_RSP.pready |-> acc && $past(acc))
    else $error("pready without two access cycles");
  err_map_a: assert property (APB_RSP.pready |-> APB_RSP.pslverr == !mapped)
    else $error("pslverr disagrees with address map");
  err_data_a: assert property (APB_RSP.pready && APB_RSP.pslverr |-> APB_RSP.prdata == 32'h0)
    else $error("error response carries data");
  bcast_mask_a: assert property (|TRIG_OUT |-> TRIG_OUT == bte)
    else $error("trigger pulses differ from enables");
  chsel_hold_a: assert property (!ADC_CHSEL_LOAD |-> $stable(ADC_CHSEL))
    else $error("channel select moved without load");
  one_kind_a: assert property (!(ADC_CHSEL_LOAD && |TRIG_OUT))
    else $error("two step kinds in one cycle");
  cover property (|TRIG_OUT);
  cover property (ADC_CHSEL_LOAD);
  cover property (APB_RSP.pready && APB_RSP.pslverr);
endmodule // tsx_step_exec_assertions

bind tsx_step_exec tsx_step_exec_assertions #(.DW(DW), .NTRIG(NTRIG), .DEPTH(DEPTH)) chk_u (
  .CLK_SYS(CLK_SYS),
  .ARST_N(ARST_N),
  .APB_REQ(APB_REQ),
  .APB_RSP(APB_RSP),
  .ADC_CHSEL(ADC_CHSEL),
  .ADC_CHSEL_LOAD(ADC_CHSEL_LOAD),
  .TRIG_OUT(TRIG_OUT)
);
